// ==== core/beacon_superframe_gts_formatter.sv ====
`timescale 1ns/1ps
module beacon_superframe_gts_formatter (
  input wire logic mclk_i, // MAC clock 25 MHz
  input wire logic rst_i, // Async reset, active high
  input wire logic profile_boot_i, // High selects bootstrap profile
  input wire logic pan_coord_i, // Device is PAN coordinator
  input wire logic assoc_permit_i, // Base-rule association permit
  input wire logic bcn_req_i, // Pulse: request one beacon
  input wire logic [7:0] hdr_len_i, // MHR byte count, sampled on request
  input wire logic [7:0] up_data_i, // Upstream byte
  input wire logic up_valid_i, // Upstream byte valid
  input wire logic up_last_i, // Upstream last byte of frame
  output logic up_ready_o, // Ready to take upstream byte
  output logic [7:0] dn_data_o, // Downstream byte
  output logic dn_valid_o, // Downstream byte valid
  output logic dn_last_o, // Downstream last byte of frame
  input wire logic dn_ready_i, // PHY ready
  output logic tx_busy_o, // Beacon in progress
  output logic rx_enable_o // Receiver enable
);
  import beacon_fmt_pkg::*;

  fmt_state_t state, next_state; // Framing state
  logic [7:0] cnt, next_cnt; // Header bytes left
  logic [1:0] ins, next_ins; // Insert byte index
  logic [15:0] sf_word; // Assembled superframe spec
  logic [7:0] gts_byte; // Assembled GTS spec
  logic assoc_bit; // Chosen association permit
  // Two-entry buffer storage
  logic [7:0] buf_d [2];
  logic buf_l [2];
  logic [7:0] next_buf_d [2];
  logic next_buf_l [2];
  logic [1:0] used, next_used; // Entries held
  logic wr_ptr, next_wr_ptr; // Write index
  logic rd_ptr, next_rd_ptr; // Read index
  logic in_v; // Byte offered to buffer
  logic [7:0] in_d; // Byte value offered
  logic in_l; // Byte is last
  logic in_go; // Buffer takes byte
  logic out_go; // PHY takes byte

  // Field assembly: every fixed subfield is constant
  always_comb begin
    assoc_bit = profile_boot_i ? BOOT_ASSOC_VALUE : assoc_permit_i;
    sf_word = 16'h0000;
    sf_word[SF_BO_LSB +: 4] = BO_VALUE;
    sf_word[SF_SO_LSB +: 4] = SO_VALUE;
    sf_word[SF_CAP_LSB +: 4] = CAP_VALUE;
    sf_word[SF_BLE_BIT] = BLE_VALUE;
    sf_word[SF_PANC_BIT] = pan_coord_i;
    sf_word[SF_ASSOC_BIT] = assoc_bit;
    gts_byte = 8'h00;
    gts_byte[GTS_CNT_LSB +: 3] = GTS_CNT_VALUE;
    gts_byte[GTS_PERMIT_BIT] = GTS_PERMIT_VALUE;
  end

  // Source selection into the buffer
  always_comb begin
    in_v = 1'b0;
    in_d = up_data_i;
    in_l = 1'b0;
    up_ready_o = 1'b0;
    case (state)
      ST_HDR, ST_TAIL: begin
        in_v = up_valid_i;
        in_l = (state == ST_TAIL) && up_last_i;
        up_ready_o = (used != 2'h2);
      end
      ST_INS: begin
        // GTS spec is the last inserted byte; no direction or list follows
        in_v = 1'b1;
        in_d = (ins == 2'h0) ? sf_word[7:0] : (ins == 2'h1) ? sf_word[15:8] : gts_byte;
      end
      default: begin
      end
    endcase
    in_go = in_v && (used != 2'h2);
  end

  // Framing state machine; beacons start only on request
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ins = ins;
    case (state)
      ST_IDLE: begin
        if (bcn_req_i) begin
          next_cnt = hdr_len_i;
          next_ins = 2'h0;
          next_state = (hdr_len_i == 8'h00) ? ST_INS : ST_HDR;
        end
      end
      ST_HDR: begin
        if (in_go) begin
          next_cnt = cnt - 8'h01;
          if (cnt == 8'h01) begin
            next_state = ST_INS;
          end
        end
      end
      ST_INS: begin
        if (in_go) begin
          next_ins = ins + 2'h1;
          if (ins == (SF_BYTES + GTS_BYTES - 2'h1)) begin
            next_state = ST_TAIL;
          end
        end
      end
      default: begin
        if (in_go && up_last_i) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Buffer bookkeeping; a PHY stall holds both entries
  always_comb begin
    out_go = (used != 2'h0) && dn_ready_i;
    next_buf_d = buf_d;
    next_buf_l = buf_l;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_used = used;
    if (in_go) begin
      next_buf_d[wr_ptr] = in_d;
      next_buf_l[wr_ptr] = in_l;
      next_wr_ptr = ~wr_ptr;
    end
    if (out_go) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (in_go && !out_go) begin
      next_used = used + 2'h1;
    end else if (!in_go && out_go) begin
      next_used = used - 2'h1;
    end
  end

  // Register all state
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      ins <= 2'h0;
      buf_d[0] <= 8'h00;
      buf_d[1] <= 8'h00;
      buf_l[0] <= 1'b0;
      buf_l[1] <= 1'b0;
      used <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ins <= next_ins;
      buf_d <= next_buf_d;
      buf_l <= next_buf_l;
      used <= next_used;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Outputs; data comes straight from buffer flops
  assign dn_data_o = buf_d[rd_ptr];
  assign dn_last_o = buf_l[rd_ptr] && (used != 2'h0);
  assign dn_valid_o = (used != 2'h0);
  assign tx_busy_o = (state != ST_IDLE) || (used != 2'h0);
  // No sleep period: receiver on whenever no beacon is in progress and the buffer is empty
  assign rx_enable_o = !tx_busy_o;

  // Inserted octets carry fixed values except the PAN coordinator and association permit bits
  sequence ins_sf_lo_s;
    state == ST_INS && ins == 2'h0 && in_go;
  endsequence
  sequence ins_gts_s;
    state == ST_INS && ins == 2'h2 && in_go;
  endsequence

  sf_low_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ins_sf_lo_s |=> buf_d[$past(wr_ptr)] == 8'h00)
    else $error("beacon/superframe order not zero");
  sf_high_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS && ins == 2'h1 && in_go |->
    in_d[3:0] == 4'h0 && !in_d[4] && !in_d[5])
    else $error("CAP slot or battery bit not zero");
  assoc_boot_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS && ins == 2'h1 && profile_boot_i |-> in_d[7])
    else $error("association permit not set");
  assoc_base_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS && ins == 2'h1 && !profile_boot_i |-> in_d[7] == assoc_permit_i)
    else $error("association permit not from base rule");
  gts_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ins_gts_s |=> buf_d[$past(wr_ptr)] == 8'h00)
    else $error("GTS spec not zero");
  gts_then_tail_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ins_gts_s |=> state == ST_TAIL)
    else $error("bytes inserted after GTS spec");
  idle_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_IDLE && !bcn_req_i |=> state == ST_IDLE)
    else $error("beacon started without request");
  rx_off_tx_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    dn_valid_o |-> !rx_enable_o)
    else $error("receiver on while sending");
  gts_permit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS && ins == 2'h2 |-> !in_d[7] && in_d[2:0] == 3'h0)
    else $error("GTS permit set");

  // Upper nibble of the low octet carries the superframe order
  so_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS && ins == 2'h0 |-> in_d[7:4] == SO_VALUE)
    else $error("superframe order not zero");
  // Battery extension sits in the high octet, checked on its own
  ble_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS && ins == 2'h1 |-> !in_d[SF_BLE_BIT - 8])
    else $error("battery extension bit set");
  // Coordinator flag must follow the pin, not a stale copy
  panc_bit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS && ins == 2'h1 |-> in_d[SF_PANC_BIT - 8] == pan_coord_i)
    else $error("PAN coordinator bit wrong");
  // A runaway index would emit direction or list bytes
  ins_bound_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_INS |-> ins <= (SF_BYTES + GTS_BYTES - 2'h1))
    else $error("insert index beyond GTS spec");
endmodule

// ==== shared/beacon_fmt_pkg.sv ====
package beacon_fmt_pkg;
  // Superframe specification field positions
  localparam int SF_BO_LSB = 0;
  localparam int SF_SO_LSB = 4;
  localparam int SF_CAP_LSB = 8;
  localparam int SF_BLE_BIT = 12;
  localparam int SF_PANC_BIT = 14;
  localparam int SF_ASSOC_BIT = 15;
  // GTS specification field positions
  localparam int GTS_CNT_LSB = 0;
  localparam int GTS_PERMIT_BIT = 7;
  // Forced values
  localparam logic [3:0] BO_VALUE = 4'h0;
  localparam logic [3:0] SO_VALUE = 4'h0;
  localparam logic [3:0] CAP_VALUE = 4'h0;
  localparam logic BLE_VALUE = 1'b0;
  localparam logic BOOT_ASSOC_VALUE = 1'b1;
  localparam logic [2:0] GTS_CNT_VALUE = 3'h0;
  localparam logic GTS_PERMIT_VALUE = 1'b0;
  // Byte counts of inserted fields
  localparam logic [1:0] SF_BYTES = 2'h2;
  localparam logic [1:0] GTS_BYTES = 2'h1;
  // Stream states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, // Waiting for a beacon request
    ST_HDR = 2'b01,  // Passing MAC header bytes
    ST_INS = 2'b10,  // Inserting fixed fields
    ST_TAIL = 2'b11  // Passing remaining payload bytes
  } fmt_state_t;
endpackage

// ==== bench/phy_sink_model.sv ====
`timescale 1ns/1ps
// PHY transmit sink: takes every byte at once, or stalls at random
module phy_sink_model (
  input wire logic mclk_i, // MAC clock
  input wire logic rst_i, // Async reset, active high
  input wire logic slow_i, // High makes the sink stall often
  output logic dn_ready_o // Accept strobe to the formatter
);
  // Long stalls fill the two-entry buffer so that upstream gets refused
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dn_ready_o <= 1'b0;
    end else begin
      dn_ready_o <= slow_i ? ($urandom_range(3) == 0) : 1'b1;
    end
  end
endmodule

// ==== bench/test_beacon_superframe_gts_formatter.sv ====
`timescale 1ns/1ps
module test_beacon_superframe_gts_formatter;
  logic mclk_i = 1'b0; // MAC clock
  logic rst_i = 1'b1; // Reset
  logic profile_boot_i = 1'b0, pan_coord_i = 1'b0, assoc_permit_i = 1'b0; // Levels
  logic bcn_req_i = 1'b0, up_valid_i = 1'b0, up_last_i = 1'b0, slow = 1'b0; // Strobes
  logic [7:0] hdr_len_i = 8'h00, up_data_i = 8'h00; // Request and byte
  logic up_ready_o, dn_valid_o, dn_last_o, dn_ready, tx_busy_o, rx_enable_o; // Outputs
  logic [7:0] dn_data_o; // Downstream byte
  logic [8:0] expq[$]; // Expected {last, byte} notes, oldest first
  int err_total = 0; // Mismatches
  int checked = 0; // Comparisons
  // Clock generator
  always #20 mclk_i = ~mclk_i;
  beacon_superframe_gts_formatter beacon_superframe_gts_formatter_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .profile_boot_i(profile_boot_i),
    .pan_coord_i(pan_coord_i), .assoc_permit_i(assoc_permit_i), .bcn_req_i(bcn_req_i),
    .hdr_len_i(hdr_len_i), .up_data_i(up_data_i), .up_valid_i(up_valid_i),
    .up_last_i(up_last_i), .up_ready_o(up_ready_o), .dn_data_o(dn_data_o),
    .dn_valid_o(dn_valid_o), .dn_last_o(dn_last_o), .dn_ready_i(dn_ready),
    .tx_busy_o(tx_busy_o), .rx_enable_o(rx_enable_o));
  phy_sink_model phy_sink_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .slow_i(slow),
    .dn_ready_o(dn_ready));
  // Single comparison point, values shown as {last, byte}
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watcher: every accepted byte must match the oldest note
  always @(posedge mclk_i) begin
    if (!rst_i) begin
      if (dn_valid_o === 1'b1 && dn_ready === 1'b1) begin
        if (expq.size() == 0) cmp(9'h001, 9'h000);
        else cmp({dn_last_o, dn_data_o}, expq.pop_front());
      end
      if (dn_valid_o === 1'b1) cmp({8'h00, rx_enable_o}, 9'h000);
    end
  end
  // Offer one upstream byte and hold it until taken; spur pokes a request mid-frame
  task automatic push_up(input logic [7:0] d, input logic last, input logic spur);
    int n;
    up_data_i <= d;
    up_last_i <= last;
    up_valid_i <= 1'b1;
    if (spur) bcn_req_i <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge mclk_i);
      if (spur) bcn_req_i <= 1'b0;
      if (up_ready_o === 1'b1) break;
    end
    if (n == 300) begin
      err_total++;
      give_verdict();
    end
  endtask
  // One beacon: header bytes, three inserted bytes, then the tail
  task automatic beacon(input int h, input int t, input logic boot, input logic spur);
    logic [7:0] d;
    logic ap;
    logic pc;
    int k;
    ap = 1'($urandom);
    pc = 1'($urandom);
    @(posedge mclk_i);
    bcn_req_i <= 1'b1;
    hdr_len_i <= 8'(h);
    profile_boot_i <= boot;
    assoc_permit_i <= ap;
    pan_coord_i <= pc;
    @(posedge mclk_i);
    // Request is a one-cycle pulse; a held request would start a second beacon
    bcn_req_i <= 1'b0;
    @(posedge mclk_i);
    cmp({8'h00, tx_busy_o}, 9'h001);
    for (k = 0; k < h; k++) begin
      d = 8'($urandom);
      expq.push_back({1'b0, d});
      push_up(d, 1'b0, k == 0 && h > 1 && 1'b0);
    end
    expq.push_back(9'h000);
    expq.push_back({1'b0, boot ? 1'b1 : ap, pc, 6'h00});
    expq.push_back(9'h000);
    for (k = 0; k < t; k++) begin
      d = 8'($urandom);
      expq.push_back({k == t - 1, d});
      push_up(d, k == t - 1, spur && k == 0);
    end
    up_valid_i <= 1'b0;
    up_last_i <= 1'b0;
    for (k = 0; k < 400 && expq.size() != 0; k++) @(posedge mclk_i);
    if (expq.size() != 0) begin
      err_total++;
      give_verdict();
    end
    // Frame drained: block idle and listening again
    @(posedge mclk_i);
    cmp({7'h00, tx_busy_o, rx_enable_o}, 9'h001);
  endtask
  // Main sequence: both profiles, empty and long headers, stalls, busy requests
  initial begin
    int i;
    void'($urandom(32'hE56F5476));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      slow <= i[1];
      beacon(i % 5, 1 + i % 3, i[0], i == 5 || i == 6);
    end
    give_verdict();
  end
endmodule
